// [src/cid_pkg.sv]
// cid_pkg: shared types and constants for the instruction decode and timing core
package cid_pkg;

	// ==========================================================
	// address spaces and operand modes
	typedef enum logic [2:0] {
		CID_SP_NONE = 3'b000,
		CID_SP_IRAM = 3'b001,
		CID_SP_SFR = 3'b010,
		CID_SP_XDATA = 3'b011,
		CID_SP_CODE = 3'b100
	} cid_space_e;

	typedef enum logic [3:0] {
		CID_AM_NONE = 4'b0000,
		CID_AM_DIRECT = 4'b0001,
		CID_AM_INDIRECT = 4'b0010,
		CID_AM_BANKREG = 4'b0011,
		CID_AM_BIT = 4'b0100,
		CID_AM_XRI = 4'b0101,
		CID_AM_XDPTR = 4'b0110,
		CID_AM_CACC_DP = 4'b0111,
		CID_AM_CACC_PC = 4'b1000
	} cid_amode_e;

	// ==========================================================
	// branch target kinds and branch conditions
	typedef enum logic [2:0] {
		CID_TG_SEQ = 3'b000,
		CID_TG_REL = 3'b001,
		CID_TG_PAGE = 3'b010,
		CID_TG_FULL = 3'b011,
		CID_TG_ACCDP = 3'b100,
		CID_TG_RET = 3'b101
	} cid_tgt_e;

	typedef enum logic [3:0] {
		CID_CD_NONE = 4'b0000,
		CID_CD_ALWAYS = 4'b0001,
		CID_CD_CY_H = 4'b0010,
		CID_CD_CY_L = 4'b0011,
		CID_CD_ACC_Z = 4'b0100,
		CID_CD_ACC_NZ = 4'b0101,
		CID_CD_BIT_H = 4'b0110,
		CID_CD_BIT_L = 4'b0111,
		CID_CD_UNEQ = 4'b1000,
		CID_CD_DEC_NZ = 4'b1001
	} cid_cond_e;

	// ==========================================================
	// decoded instruction
	typedef struct packed {
		logic known;
		logic [1:0] len;
		logic [2:0] base;
		cid_cond_e cond;
		cid_tgt_e tgt;
		cid_amode_e amode;
		logic rel_hi;
		logic acc_ld;
		logic ram_ld;
		logic nib;
		logic call;
		logic ret;
		logic bclr;
	} cid_dec_s;

	// ==========================================================
	// field positions and fixed values
	localparam int CID_UPPER_BIT = 7;
	localparam int CID_BANK_LO = 3;
	localparam int CID_BANK_HI = 4;
	localparam int CID_PAGE_LSB = 11;
	localparam logic [3:0] CID_BIT_RAM_BASE = 4'h2;
	localparam logic [7:0] CID_OP_NOP = 8'h00;
	localparam logic [7:0] CID_OP_SPARE = 8'hA5;
	localparam logic [7:0] CID_OP_SHORT_RELATIVE_JUMP = 8'h80;
	localparam logic [7:0] CID_OP_FAR_JUMP = 8'h02;
	localparam logic [7:0] CID_OP_JZ = 8'h60;
	localparam logic [7:0] CID_OP_JBC = 8'h10;
	localparam logic [7:0] CID_OP_RET = 8'h22;
	localparam logic [7:0] CID_OP_MOV_A_DIR = 8'hE5;
	localparam logic [7:0] CID_OP_MOV_A_R0 = 8'hE8;
	localparam logic [7:0] CID_OP_MOV_A_IND0 = 8'hE6;
	localparam logic [7:0] CID_OP_XCHD0 = 8'hD6;
	localparam logic [7:0] CID_OP_COMPARE_BRANCH_UNEQUAL_DIR = 8'hB5;

endpackage

// [src/cid_target.sv]
// cid_target: branch destination arithmetic
module cid_target (
	input wire cid_pkg::cid_tgt_e i_tgt,
	input wire logic [15:0] i_pc_next,
	input wire logic [7:0] i_rel,
	input wire logic [2:0] i_page_hi,
	input wire logic [7:0] i_byte1,
	input wire logic [7:0] i_byte2,
	input wire logic [7:0] i_acc,
	input wire logic [15:0] i_data_pointer_reg,
	input wire logic [15:0] i_ret_pc,
	output logic [15:0] o_target
);

	// ==========================================================
	// destination select
	always_comb begin
		unique case (i_tgt)
			cid_pkg::CID_TG_REL: o_target = i_pc_next + {{8{i_rel[7]}}, i_rel};
			cid_pkg::CID_TG_PAGE: o_target = {i_pc_next[15:cid_pkg::CID_PAGE_LSB], i_page_hi,
				i_byte1};
			cid_pkg::CID_TG_FULL: o_target = {i_byte1, i_byte2};
			cid_pkg::CID_TG_ACCDP: o_target = i_data_pointer_reg + {8'h00, i_acc};
			cid_pkg::CID_TG_RET: o_target = i_ret_pc;
			default: o_target = i_pc_next;
		endcase
	end

endmodule

// [src/cid_space_sel.sv]
// cid_space_sel: operand address and memory space selection
module cid_space_sel (
	input wire cid_pkg::cid_amode_e i_amode,
	input wire logic [7:0] i_byte1,
	input wire logic [7:0] i_ri_val,
	input wire logic [1:0] i_bank,
	input wire logic [2:0] i_reg,
	input wire logic [7:0] i_acc,
	input wire logic [15:0] i_data_pointer_reg,
	input wire logic [15:0] i_pc_next,
	output cid_pkg::cid_space_e o_space,
	output logic [7:0] o_addr,
	output logic [15:0] o_xaddr,
	output logic [7:0] o_idx_addr
);

	// ==========================================================
	// index register location in the active bank
	assign o_idx_addr = {3'b000, i_bank, 2'b00, i_reg[0]};

	// ==========================================================
	// space and address per operand mode
	always_comb begin
		o_space = cid_pkg::CID_SP_NONE;
		o_addr = 8'h00;
		o_xaddr = 16'h0000;
		unique case (i_amode)
			cid_pkg::CID_AM_DIRECT: begin
				o_space = i_byte1[cid_pkg::CID_UPPER_BIT] ? cid_pkg::CID_SP_SFR
					: cid_pkg::CID_SP_IRAM;
				o_addr = i_byte1;
			end
			cid_pkg::CID_AM_INDIRECT: begin
				o_space = cid_pkg::CID_SP_IRAM;
				o_addr = i_ri_val;
			end
			cid_pkg::CID_AM_BANKREG: begin
				o_space = cid_pkg::CID_SP_IRAM;
				o_addr = {3'b000, i_bank, i_reg};
			end
			cid_pkg::CID_AM_BIT: begin
				o_space = i_byte1[cid_pkg::CID_UPPER_BIT] ? cid_pkg::CID_SP_SFR
					: cid_pkg::CID_SP_IRAM;
				o_addr = i_byte1[cid_pkg::CID_UPPER_BIT] ? {i_byte1[7:3], 3'b000}
					: {cid_pkg::CID_BIT_RAM_BASE, i_byte1[6:3]};
			end
			cid_pkg::CID_AM_XRI: begin
				o_space = cid_pkg::CID_SP_XDATA;
				o_xaddr = {8'h00, i_ri_val};
			end
			cid_pkg::CID_AM_XDPTR: begin
				o_space = cid_pkg::CID_SP_XDATA;
				o_xaddr = i_data_pointer_reg;
			end
			cid_pkg::CID_AM_CACC_DP: begin
				o_space = cid_pkg::CID_SP_CODE;
				o_xaddr = i_data_pointer_reg + {8'h00, i_acc};
			end
			cid_pkg::CID_AM_CACC_PC: begin
				o_space = cid_pkg::CID_SP_CODE;
				o_xaddr = i_pc_next + {8'h00, i_acc};
			end
			default: o_space = cid_pkg::CID_SP_NONE;
		endcase
	end

endmodule

// [src/cid_decode.sv]
// cid_decode: instruction decode, branch resolution and cycle timing
// ==========================================================
module cid_decode (
	input wire logic i_mclk,
	input wire logic i_sys_rst,
	input wire logic i_start,
	input wire logic [7:0] i_opcode,
	input wire logic [7:0] i_byte1,
	input wire logic [7:0] i_byte2,
	input wire logic [15:0] i_pc,
	input wire logic [7:0] i_acc,
	input wire logic i_carry,
	input wire logic [7:0] i_psw,
	input wire logic [15:0] i_data_pointer_reg,
	input wire logic [7:0] i_ri_val,
	input wire logic [7:0] i_reg_data,
	input wire logic [7:0] i_ind_data,
	input wire logic [7:0] i_dir_data,
	input wire logic i_bit_val,
	input wire logic [15:0] i_ret_pc,
	output logic o_busy,
	output logic o_done,
	output logic o_known,
	output logic o_taken,
	output logic [1:0] o_len,
	output logic [2:0] o_cycles,
	output logic [15:0] o_next_pc,
	output cid_pkg::cid_space_e o_space,
	output logic [7:0] o_dat_addr,
	output logic [15:0] o_ext_addr,
	output logic [7:0] o_idx_addr,
	output logic o_acc_we,
	output logic [7:0] o_acc_res,
	output logic o_ram_we,
	output logic [7:0] o_ram_res,
	output logic o_bit_clr,
	output logic o_call,
	output logic o_ret
);

	// ==========================================================
	// state record
	typedef struct packed {
		logic busy;
		logic [2:0] cnt;
		logic done;
		logic known;
		logic taken;
		logic [1:0] len;
		logic [2:0] cyc;
		logic [15:0] next_pc;
		cid_pkg::cid_space_e space;
		logic [7:0] addr;
		logic [15:0] xaddr;
		logic [7:0] idx;
		logic [7:0] acc_res;
		logic [7:0] ram_res;
		logic p_acc;
		logic p_ram;
		logic p_bclr;
		logic p_call;
		logic p_ret;
		logic acc_we;
		logic ram_we;
		logic bit_clr;
		logic call;
		logic ret;
	} cid_st_s;

	cid_st_s r;
	cid_st_s n;
	cid_pkg::cid_dec_s d;
	logic accept;
	logic [15:0] pc_next;
	logic [15:0] target;
	logic [7:0] opnd;
	logic [7:0] cmp_rhs;
	logic cond_ok;
	logic branch;
	cid_pkg::cid_space_e sp;
	logic [7:0] sp_addr;
	logic [15:0] sp_xaddr;
	logic [7:0] sp_idx;

	// ==========================================================
	// opcode table: length, base cycles, operands, branch kind
	function automatic cid_pkg::cid_dec_s decode(input logic [7:0] op);
		cid_pkg::cid_dec_s t;
		t = '0;
		t.known = 1'b1;
		t.len = 2'd1;
		t.base = 3'd1;
		t.cond = cid_pkg::CID_CD_NONE;
		t.tgt = cid_pkg::CID_TG_SEQ;
		t.amode = cid_pkg::CID_AM_NONE;
		unique casez (op)
			cid_pkg::CID_OP_NOP, cid_pkg::CID_OP_SPARE: t.len = 2'd1;
			8'h13, 8'hC4: t.len = 2'd1;
			8'b1110_1???: begin // accumulator from bank register
				t.amode = cid_pkg::CID_AM_BANKREG;
				t.acc_ld = 1'b1;
			end
			8'b1111_1???: begin
				t.amode = cid_pkg::CID_AM_BANKREG;
				t.ram_ld = 1'b1;
			end
			8'b1100_1???: begin
				t.amode = cid_pkg::CID_AM_BANKREG;
				t.acc_ld = 1'b1;
				t.ram_ld = 1'b1;
			end
			8'b1110_011?, 8'b1111_011?, 8'b1100_011?, 8'b1101_011?: begin
				t.amode = cid_pkg::CID_AM_INDIRECT;
				t.base = 3'd2;
				t.acc_ld = (op[5:4] != 2'b11);
				t.ram_ld = (op[5:4] != 2'b10);
				t.nib = (op[5:4] == 2'b01);
			end
			8'hE5, 8'hF5, 8'b1000_1???, 8'h86, 8'h87, 8'hC0, 8'hD0, 8'hC5: begin
				t.amode = cid_pkg::CID_AM_DIRECT;
				t.len = 2'd2;
				t.base = 3'd2;
			end
			8'h74, 8'b1010_1???, 8'b0111_1???, 8'b1010_011?, 8'b0111_011?: begin
				t.amode = op[3] ? cid_pkg::CID_AM_BANKREG : op[1] ? cid_pkg::CID_AM_INDIRECT
					: cid_pkg::CID_AM_NONE; // immediate to accumulator has no memory operand
				t.len = 2'd2;
				t.base = 3'd2;
			end
			8'h85, 8'h75: begin
				t.amode = cid_pkg::CID_AM_DIRECT;
				t.len = 2'd3;
				t.base = 3'd3;
			end
			8'h90: begin
				t.len = 2'd3;
				t.base = 3'd3;
			end
			8'h93, 8'h83: begin
				t.amode = op[4] ? cid_pkg::CID_AM_CACC_DP : cid_pkg::CID_AM_CACC_PC;
				t.base = 3'd3;
			end
			8'hE0, 8'hF0, 8'hE2, 8'hE3, 8'hF2, 8'hF3: begin
				t.amode = op[1] ? cid_pkg::CID_AM_XRI : cid_pkg::CID_AM_XDPTR;
				t.base = 3'd3;
			end
			8'hC3, 8'hD3, 8'hB3: t.base = 3'd1;
			8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92: begin
				t.amode = cid_pkg::CID_AM_BIT;
				t.len = 2'd2;
				t.base = 3'd2;
			end
			8'h40, 8'h50, 8'h60, 8'h70, cid_pkg::CID_OP_SHORT_RELATIVE_JUMP: begin
				t.len = 2'd2;
				t.base = (op == cid_pkg::CID_OP_SHORT_RELATIVE_JUMP) ? 3'd3 : 3'd2;
				t.tgt = cid_pkg::CID_TG_REL;
				unique case (op[6:4])
					3'b100: t.cond = cid_pkg::CID_CD_CY_H;
					3'b101: t.cond = cid_pkg::CID_CD_CY_L;
					3'b110: t.cond = cid_pkg::CID_CD_ACC_Z;
					3'b111: t.cond = cid_pkg::CID_CD_ACC_NZ;
					default: t.cond = cid_pkg::CID_CD_ALWAYS;
				endcase
			end
			8'h20, 8'h30, cid_pkg::CID_OP_JBC: begin
				t.amode = cid_pkg::CID_AM_BIT;
				t.len = 2'd3;
				t.base = 3'd3;
				t.tgt = cid_pkg::CID_TG_REL;
				t.rel_hi = 1'b1;
				t.cond = (op == 8'h30) ? cid_pkg::CID_CD_BIT_L : cid_pkg::CID_CD_BIT_H;
				t.bclr = (op == cid_pkg::CID_OP_JBC);
			end
			8'b???1_0001, 8'b???0_0001: begin
				t.len = 2'd2;
				t.base = 3'd3;
				t.tgt = cid_pkg::CID_TG_PAGE;
				t.cond = cid_pkg::CID_CD_ALWAYS;
				t.call = op[4];
			end
			8'h12, cid_pkg::CID_OP_FAR_JUMP: begin
				t.len = 2'd3;
				t.base = 3'd4;
				t.tgt = cid_pkg::CID_TG_FULL;
				t.cond = cid_pkg::CID_CD_ALWAYS;
				t.call = op[4];
			end
			cid_pkg::CID_OP_RET, 8'h32: begin
				t.base = 3'd5;
				t.tgt = cid_pkg::CID_TG_RET;
				t.cond = cid_pkg::CID_CD_ALWAYS;
				t.ret = 1'b1;
			end
			8'h73: begin
				t.base = 3'd3;
				t.tgt = cid_pkg::CID_TG_ACCDP;
				t.cond = cid_pkg::CID_CD_ALWAYS;
			end
			cid_pkg::CID_OP_COMPARE_BRANCH_UNEQUAL_DIR, 8'hB4, 8'b1011_1???, 8'hB6, 8'hB7: begin
				t.len = 2'd3;
				t.base = (op[3:1] == 3'b011) ? 3'd4 : 3'd3;
				t.tgt = cid_pkg::CID_TG_REL;
				t.rel_hi = 1'b1;
				t.cond = cid_pkg::CID_CD_UNEQ;
				t.amode = op[3] ? cid_pkg::CID_AM_BANKREG : op[1] ? cid_pkg::CID_AM_INDIRECT
					: op[0] ? cid_pkg::CID_AM_DIRECT : cid_pkg::CID_AM_NONE;
			end
			8'b1101_1???, 8'hD5: begin
				t.len = op[3] ? 2'd2 : 2'd3;
				t.base = op[3] ? 3'd2 : 3'd3;
				t.tgt = cid_pkg::CID_TG_REL;
				t.rel_hi = ~op[3];
				t.cond = cid_pkg::CID_CD_DEC_NZ;
				t.amode = op[3] ? cid_pkg::CID_AM_BANKREG : cid_pkg::CID_AM_DIRECT;
			end
			default: t.known = 1'b0;
		endcase
		return t;
	endfunction

	// ==========================================================
	// decode and operand selection for the offered instruction
	assign d = decode(i_opcode);
	assign accept = i_start && !r.busy;
	assign pc_next = i_pc + {14'h0000, d.len};
	assign opnd = (d.amode == cid_pkg::CID_AM_BANKREG) ? i_reg_data
		: (d.amode == cid_pkg::CID_AM_INDIRECT) ? i_ind_data : i_dir_data;
	assign cmp_rhs = (i_opcode == cid_pkg::CID_OP_COMPARE_BRANCH_UNEQUAL_DIR) ? i_dir_data : i_byte1;

	// branch condition evaluation
	always_comb begin
		unique case (d.cond)
			cid_pkg::CID_CD_ALWAYS: cond_ok = 1'b1;
			cid_pkg::CID_CD_CY_H: cond_ok = i_carry;
			cid_pkg::CID_CD_CY_L: cond_ok = ~i_carry;
			cid_pkg::CID_CD_ACC_Z: cond_ok = (i_acc == 8'h00);
			cid_pkg::CID_CD_ACC_NZ: cond_ok = (i_acc != 8'h00);
			cid_pkg::CID_CD_BIT_H: cond_ok = i_bit_val;
			cid_pkg::CID_CD_BIT_L: cond_ok = ~i_bit_val;
			cid_pkg::CID_CD_UNEQ: cond_ok = ((d.amode == cid_pkg::CID_AM_BANKREG
				|| d.amode == cid_pkg::CID_AM_INDIRECT) ? opnd : i_acc) != cmp_rhs;
			cid_pkg::CID_CD_DEC_NZ: cond_ok = (opnd != 8'h01);
			default: cond_ok = 1'b0;
		endcase
	end
	assign branch = (d.cond != cid_pkg::CID_CD_NONE) && (d.cond != cid_pkg::CID_CD_ALWAYS);

	// ==========================================================
	// target arithmetic and operand space
	cid_target u_target (
		.i_tgt(d.tgt),
		.i_pc_next(pc_next),
		.i_rel(d.rel_hi ? i_byte2 : i_byte1),
		.i_page_hi(i_opcode[7:5]),
		.i_byte1(i_byte1),
		.i_byte2(i_byte2),
		.i_acc(i_acc),
		.i_data_pointer_reg(i_data_pointer_reg),
		.i_ret_pc(i_ret_pc),
		.o_target(target)
	);

	cid_space_sel u_space (
		.i_amode(d.amode),
		.i_byte1(i_byte1),
		.i_ri_val(i_ri_val),
		.i_bank(i_psw[cid_pkg::CID_BANK_HI:cid_pkg::CID_BANK_LO]),
		.i_reg(i_opcode[2:0]),
		.i_acc(i_acc),
		.i_data_pointer_reg(i_data_pointer_reg),
		.i_pc_next(pc_next),
		.o_space(sp),
		.o_addr(sp_addr),
		.o_xaddr(sp_xaddr),
		.o_idx_addr(sp_idx)
	);

	// ==========================================================
	// sequencing: load on accept, count down, pulse done at the end
	always_comb begin
		n = r;
		n.done = 1'b0;
		n.acc_we = 1'b0;
		n.ram_we = 1'b0;
		n.bit_clr = 1'b0;
		n.call = 1'b0;
		n.ret = 1'b0;
		if (r.busy) begin
			if (r.cnt == 3'd1) begin
				n.busy = 1'b0;
				n.done = 1'b1;
				n.acc_we = r.p_acc;
				n.ram_we = r.p_ram;
				n.bit_clr = r.p_bclr && r.taken;
				n.call = r.p_call;
				n.ret = r.p_ret;
			end else begin
				n.cnt = r.cnt - 3'd1;
			end
		end else if (i_start) begin
			n.busy = 1'b1;
			n.known = d.known;
			n.len = d.len;
			n.taken = cond_ok;
			n.cyc = d.base + {2'b00, branch && cond_ok};
			n.cnt = d.base + {2'b00, branch && cond_ok};
			n.next_pc = cond_ok ? target : pc_next;
			n.space = sp;
			n.addr = sp_addr;
			n.xaddr = sp_xaddr;
			n.idx = sp_idx;
			n.acc_res = d.nib ? {i_acc[7:4], opnd[3:0]} : opnd;
			n.ram_res = d.nib ? {opnd[7:4], i_acc[3:0]} : i_acc;
			n.p_acc = d.acc_ld;
			n.p_ram = d.ram_ld;
			n.p_bclr = d.bclr;
			n.p_call = d.call;
			n.p_ret = d.ret;
		end
	end

	// state register
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	// outputs straight from the state register
	assign o_busy = r.busy;
	assign o_done = r.done;
	assign o_known = r.known;
	assign o_taken = r.taken;
	assign o_len = r.len;
	assign o_cycles = r.cyc;
	assign o_next_pc = r.next_pc;
	assign o_space = r.space;
	assign o_dat_addr = r.addr;
	assign o_ext_addr = r.xaddr;
	assign o_idx_addr = r.idx;
	assign o_acc_we = r.acc_we;
	assign o_acc_res = r.acc_res;
	assign o_ram_we = r.ram_we;
	assign o_ram_res = r.ram_res;
	assign o_bit_clr = r.bit_clr;
	assign o_call = r.call;
	assign o_ret = r.ret;

	// ==========================================================
	// checks: helper captures of the accepted instruction
	logic [7:0] h_op;
	logic [7:0] h_b1;
	logic [7:0] h_b2;
	logic [7:0] h_acc;
	logic [7:0] h_ind;
	logic [1:0] h_bank;
	logic [15:0] h_pcn;
	logic [15:0] h_rel;

	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			h_op <= 8'h00;
			h_b1 <= 8'h00;
			h_b2 <= 8'h00;
			h_acc <= 8'h00;
			h_ind <= 8'h00;
			h_bank <= 2'b00;
			h_pcn <= 16'h0000;
			h_rel <= 16'h0000;
		end else if (accept) begin
			h_op <= i_opcode;
			h_b1 <= i_byte1;
			h_b2 <= i_byte2;
			h_acc <= i_acc;
			h_ind <= i_ind_data;
			h_bank <= i_psw[cid_pkg::CID_BANK_HI:cid_pkg::CID_BANK_LO];
			h_pcn <= pc_next;
			h_rel <= i_pc + 16'h0002 + {{8{i_byte1[7]}}, i_byte1};
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	sequence s_run1;
		o_busy ##1 (!o_busy && o_done);
	endsequence
	sequence s_run2;
		o_busy[*2] ##1 (!o_busy && o_done);
	endsequence
	sequence s_run3;
		o_busy[*3] ##1 (!o_busy && o_done);
	endsequence
	sequence s_run5;
		o_busy[*5] ##1 (!o_busy && o_done);
	endsequence

	a_xdata_time: assert property (accept && (d.amode == cid_pkg::CID_AM_XRI
		|| d.amode == cid_pkg::CID_AM_XDPTR) |=> s_run3 ##0 o_space == cid_pkg::CID_SP_XDATA)
		else $error("external data move not three cycles");
	a_code_time: assert property (accept && (d.amode == cid_pkg::CID_AM_CACC_DP
		|| d.amode == cid_pkg::CID_AM_CACC_PC) |=> s_run3 ##0 o_space == cid_pkg::CID_SP_CODE)
		else $error("code byte read not three cycles");
	a_bank_one: assert property (accept
		&& i_opcode[7:3] == cid_pkg::CID_OP_MOV_A_R0[7:3] |=> s_run1 ##0 o_acc_we)
		else $error("bank register move not one cycle");
	a_bank_addr: assert property (o_done
		&& h_op[7:3] == cid_pkg::CID_OP_MOV_A_R0[7:3] |-> o_dat_addr == {3'b000, h_bank, h_op[2:0]})
		else $error("bank register address wrong");
	a_ind_two: assert property (accept
		&& i_opcode[7:1] == cid_pkg::CID_OP_MOV_A_IND0[7:1] |=> s_run2)
		else $error("indirect move not two cycles");
	a_nibble_swap: assert property (o_done
		&& h_op[7:1] == cid_pkg::CID_OP_XCHD0[7:1] |-> o_acc_we && o_ram_we
		&& o_acc_res == {h_acc[7:4], h_ind[3:0]} && o_ram_res == {h_ind[7:4], h_acc[3:0]})
		else $error("nibble exchange result wrong");
	a_jz_untaken: assert property (accept && i_opcode == cid_pkg::CID_OP_JZ
		&& i_acc != 8'h00 |=> o_busy[*2] ##1 (o_done && !o_taken && o_next_pc == h_pcn))
		else $error("untaken zero jump not two cycles");
	a_jbc_clear: assert property (accept && i_opcode == cid_pkg::CID_OP_JBC
		&& i_bit_val |=> o_busy[*4] ##1 (o_done && o_taken && o_bit_clr))
		else $error("taken bit jump did not clear in four cycles");
	a_ret_five: assert property (accept && i_opcode == cid_pkg::CID_OP_RET
		|=> s_run5 ##0 o_ret)
		else $error("return not five cycles");
	a_far_jump: assert property (accept && i_opcode == cid_pkg::CID_OP_FAR_JUMP
		|=> o_busy[*4] ##1 (o_done && o_next_pc == {h_b1, h_b2}))
		else $error("far jump target or timing wrong");
	a_rel_target: assert property (o_done && h_op == cid_pkg::CID_OP_SHORT_RELATIVE_JUMP
		|-> o_next_pc == h_rel && o_cycles == 3'd3)
		else $error("relative target wrong");
	a_page_keep: assert property (o_done && h_op[3:0] == 4'b0001
		|-> o_next_pc == {h_pcn[15:11], h_op[7:5], h_b1})
		else $error("page target left its page");
	a_direct_space: assert property (accept
		&& i_opcode == cid_pkg::CID_OP_MOV_A_DIR |=> o_dat_addr == $past(i_byte1)
		&& o_space == (h_b1[7] ? cid_pkg::CID_SP_SFR : cid_pkg::CID_SP_IRAM))
		else $error("direct operand space wrong");
	a_nop_quiet: assert property (accept && (i_opcode == cid_pkg::CID_OP_NOP
		|| i_opcode == cid_pkg::CID_OP_SPARE) |=> s_run1 ##0 (!o_acc_we && !o_ram_we
		&& o_space == cid_pkg::CID_SP_NONE && o_next_pc == h_pcn))
		else $error("spare opcode not a no-operation");

endmodule

// [tb/cid_mem_model.sv]
// cid_mem_model: behavioural internal data memory beside the decoder
module cid_mem_model (
	input wire logic [7:0] i_addr,
	output logic [7:0] o_data
);
	timeunit 1ns;
	timeprecision 1ns;
	// each byte holds a fixed pattern of its own address
	assign o_data = i_addr ^ 8'h5A;
endmodule

// [tb/cid_decode_tb.sv]
// cid_decode_tb: self-checking bench for the decode and timing core
`define CHK(nm, e, s) begin check_count++; if ((e) !== (s)) begin err_total++; \
	$display("[FAIL] %s exp %h got %h", nm, e, s); end end
module cid_decode_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_mclk, i_sys_rst, i_start, i_carry, i_bit_val, clr_v;
	logic [7:0] i_opcode, i_byte1, i_byte2, i_acc, i_psw, i_ri_val, i_reg_data, i_ind_data;
	logic [7:0] i_dir_data, o_dat_addr, o_idx_addr, o_acc_res, o_ram_res;
	logic [15:0] i_pc, i_data_pointer_reg, i_ret_pc, pc_v, o_next_pc, o_ext_addr;
	logic o_busy, o_done, o_known, o_taken, o_acc_we, o_ram_we, o_bit_clr, o_call, o_ret;
	logic [1:0] o_len;
	logic [2:0] o_cycles;
	cid_pkg::cid_space_e o_space;
	int err_total, check_count;

	// ==========================================================
	// design and memory model
	cid_mem_model mem (.i_addr(i_byte1), .o_data(i_dir_data));
	cid_decode dut (.*);

	// 20 MHz clock
	initial begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end

	// ==========================================================
	// verdict and shared transfer task
	task automatic final_report();
		if (err_total == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// offer one instruction, count busy cycles, check timing and target
	task automatic run(input logic [23:0] ins, input logic [2:0] cyc, input logic [1:0] len,
		input logic [15:0] npc);
		int n;
		n = 0;
		@(posedge i_mclk);
		{i_opcode, i_byte1, i_byte2} <= ins;
		i_pc <= pc_v;
		i_start <= 1'b1;
		@(posedge i_mclk);
		i_start <= 1'b0;
		#1;
		while (o_done !== 1'b1 && n < 8) begin
			`CHK("busy", 1'b1, o_busy)
			n++;
			@(posedge i_mclk);
			#1;
		end
		if (n >= 8) begin
			err_total++;
			final_report();
		end
		clr_v = o_bit_clr;
		`CHK("cycles", cyc, n[2:0])
		`CHK("o_cycles", cyc, o_cycles)
		`CHK("o_len", len, o_len)
		`CHK("o_next_pc", npc, o_next_pc)
	endtask

	// ==========================================================
	// scenarios
	task automatic t_moves();
		run(24'h00_0000, 3'h1, 2'h1, 16'h1001);
		run(24'hA5_0000, 3'h1, 2'h1, 16'h1001);
		`CHK("known", 1'b1, o_known)
		run(24'hE0_0000, 3'h3, 2'h1, 16'h1001);
		run(24'hF2_0000, 3'h3, 2'h1, 16'h1001);
		run(24'h93_0000, 3'h3, 2'h1, 16'h1001);
		run(24'hC8_0000, 3'h1, 2'h1, 16'h1001);
		run(24'hC6_0000, 3'h2, 2'h1, 16'h1001);
		run(24'h85_3040, 3'h3, 2'h3, 16'h1003);
		run(24'h90_1234, 3'h3, 2'h3, 16'h1003);
		run(24'hC3_0000, 3'h1, 2'h1, 16'h1001);
		run(24'hB2_0800, 3'h2, 2'h2, 16'h1002);
		run(24'h28_0000, 3'h1, 2'h1, 16'h1001);
		`CHK("known", 1'b0, o_known)
	endtask

	task automatic t_nibble();
		@(posedge i_mclk);
		i_acc <= 8'hA3;
		i_ind_data <= 8'h5C;
		run(24'hD6_0000, 3'h2, 2'h1, 16'h1001);
		`CHK("acc_res", 8'hAC, o_acc_res)
		`CHK("ram_res", 8'h53, o_ram_res)
		`CHK("acc_we", 1'b1, o_acc_we)
		`CHK("ram_we", 1'b1, o_ram_we)
	endtask

	task automatic t_cond();
		@(posedge i_mclk);
		i_acc <= 8'h00;
		i_carry <= 1'b1;
		i_bit_val <= 1'b1;
		run(24'h60_F000, 3'h3, 2'h2, 16'h0FF2);
		`CHK("taken", 1'b1, o_taken)
		run(24'h70_F000, 3'h2, 2'h2, 16'h1002);
		`CHK("taken", 1'b0, o_taken)
		run(24'h40_0500, 3'h3, 2'h2, 16'h1007);
		run(24'h50_0500, 3'h2, 2'h2, 16'h1002);
		run(24'h20_2210, 3'h4, 2'h3, 16'h1013);
		`CHK("bit_clr", 1'b0, o_bit_clr)
		run(24'h30_2210, 3'h3, 2'h3, 16'h1003);
		run(24'h10_2210, 3'h4, 2'h3, 16'h1013);
		`CHK("bit_clr", 1'b1, clr_v)
	endtask

	task automatic t_jumps();
		@(posedge i_mclk);
		i_ret_pc <= 16'h2345;
		i_data_pointer_reg <= 16'h2000;
		i_acc <= 8'h10;
		pc_v = 16'h17FE;
		run(24'h31_4400, 3'h3, 2'h2, 16'h1944);
		`CHK("call", 1'b1, o_call)
		pc_v = 16'h1000;
		run(24'h12_ABCD, 3'h4, 2'h3, 16'hABCD);
		run(24'h22_0000, 3'h5, 2'h1, 16'h2345);
		`CHK("ret", 1'b1, o_ret)
		run(24'h32_0000, 3'h5, 2'h1, 16'h2345);
		run(24'h01_1000, 3'h3, 2'h2, 16'h1010);
		run(24'h02_FEDC, 3'h4, 2'h3, 16'hFEDC);
		run(24'h80_7F00, 3'h3, 2'h2, 16'h1081);
		run(24'h73_0000, 3'h3, 2'h1, 16'h2010);
		run(24'hE0_0000, 3'h3, 2'h1, 16'h1001);
		`CHK("ext_addr", 16'h2000, o_ext_addr)
		run(24'h93_0000, 3'h3, 2'h1, 16'h1001);
		`CHK("ext_addr", 16'h2010, o_ext_addr)
		run(24'h83_0000, 3'h3, 2'h1, 16'h1001);
		`CHK("space", cid_pkg::CID_SP_CODE, o_space)
		`CHK("ext_addr", 16'h1011, o_ext_addr)
	endtask

	task automatic t_loops();
		@(posedge i_mclk);
		i_acc <= 8'h6A;
		i_ind_data <= 8'h55;
		i_reg_data <= 8'h01;
		run(24'hB5_3020, 3'h3, 2'h3, 16'h1003);
		run(24'hB5_3120, 3'h4, 2'h3, 16'h1023);
		run(24'hB6_5520, 3'h4, 2'h3, 16'h1003);
		run(24'hD8_1000, 3'h2, 2'h2, 16'h1002);
		run(24'hD5_5B10, 3'h3, 2'h3, 16'h1003);
		run(24'hB6_5420, 3'h5, 2'h3, 16'h1023);
		run(24'hD5_5A10, 3'h4, 2'h3, 16'h1013);
	endtask

	task automatic t_space();
		@(posedge i_mclk);
		i_psw <= 8'h10;
		i_ri_val <= 8'h90;
		run(24'hE5_9000, 3'h2, 2'h2, 16'h1002);
		`CHK("space", cid_pkg::CID_SP_SFR, o_space)
		run(24'hE7_0000, 3'h2, 2'h1, 16'h1001);
		`CHK("space", cid_pkg::CID_SP_IRAM, o_space)
		`CHK("dat_addr", 8'h90, o_dat_addr)
		`CHK("idx_addr", 8'h11, o_idx_addr)
		run(24'hEB_0000, 3'h1, 2'h1, 16'h1001);
		`CHK("dat_addr", 8'h13, o_dat_addr)
	endtask

	// ==========================================================
	// main sequence
	initial begin
		i_sys_rst = 1'b1;
		i_start = 1'b0;
		{i_opcode, i_byte1, i_byte2, i_acc, i_psw, i_ri_val, i_reg_data, i_ind_data} = '0;
		{i_carry, i_bit_val, i_pc, i_data_pointer_reg, i_ret_pc} = '0;
		pc_v = 16'h1000;
		err_total = 0;
		check_count = 0;
		repeat (8) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		t_moves();
		t_nibble();
		t_cond();
		t_jumps();
		t_loops();
		t_space();
		final_report();
	end
endmodule
